// ### design/dde_regs.vh
/*
  Register map, field positions, reset values and counts of the converter
  dither and event control block. Included by the control logic design file by bare name.
*/
`ifndef DDE_REGS_VH
`define DDE_REGS_VH

// register indices; byte address is four times the index
`define DDE_IDX_CTRLA 4'h0
`define DDE_IDX_CTRL2 4'h1
`define DDE_IDX_EVT_CTRL 4'h2
`define DDE_IDX_IRQ_CLR 4'h4
`define DDE_IDX_IRQ_SET 4'h5
`define DDE_IDX_INTFLAG 4'h6
`define DDE_IDX_STATUS 4'h7
`define DDE_IDX_DATA 4'h8
`define DDE_IDX_STAGE 4'h9

// main control fields
`define DDE_CTRLA_ENABLE 0
// second control fields
`define DDE_CTRL2_DITHER 0
`define DDE_CTRL2_LEFT_ALIGN 1
// event control fields
`define DDE_EV_START_IN_EN 0
`define DDE_EV_EMPTY_OUT_EN 1
`define DDE_EV_EDGE_INVERT 2
// interrupt enable and flag fields
`define DDE_IRQ_UNDERRUN 0
`define DDE_IRQ_EMPTY 1

// reset values
`define DDE_RST_CTRLA 1'h0
`define DDE_RST_CTRL2 2'h0
`define DDE_RST_EVT_CTRL 3'h0
`define DDE_RST_INTEN 2'h0
`define DDE_RST_FLAG 2'h0
`define DDE_RST_DATA 16'h0000

// dithering: sub-conversions per data value
`define DDE_DITHER_SUBS 16
`define DDE_CODE_MAX 10'h3ff

`endif

// ### design/dde_fifo.v
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dde_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // filling side
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  // draining side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);

  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign o_in_ready = (count_ff != D[AW:0]);
  assign o_out_valid = (count_ff != {(AW+1){1'b0}});
  assign o_out_data = mem_ff[rd_ptr_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  genvar g;
  generate
    for (g = 0; g < D; g = g + 1) begin : g_entry
      localparam [AW-1:0] SLOT = g;
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          mem_ff[g] <= {W{1'b0}};
        end else if (push && wr_ptr_ff == SLOT) begin
          mem_ff[g] <= i_in_data;
        end
      end
    end
  endgenerate

  // pointers wrap naturally; depth is a power of two
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule // dde_fifo
`default_nettype wire

// ### design/dde_ctrl.v
/*
  Control logic of a 10-bit converter: data staging, dithering, left
  alignment, start-event input, buffer-empty event and interrupt enables,
  with an APB register slave. Assumes one 50 MHz clock, an asynchronous
  active-high reset and a start-event line from another domain.
*/
// Overview of operation
// - dither: sixteen sub-conversions, code or code plus one
// - dither: empty event once per sixteen sub-conversions
// - left alignment takes code and dither higher
// - invert bit picks rising or falling edge
// - empty event only while its enable set
// - start enable lets events load and convert
// - clear register disables enables, seen in set
// - writing zero to clear bits changes nothing
// - staging buffer and data form two-stage queue
// - event needing a load on empty staging flags underrun interrupt
// - dither value: code bits 13:4, dither 3:0
`timescale 1ns/1ps
`default_nettype none
`include "dde_regs.vh"
module dde_ctrl #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // event system
  input wire i_start_evt,
  output reg o_empty_evt,
  // dma and interrupt
  output reg o_dma_req,
  output reg o_irq,
  // converter
  output reg [9:0] o_dac_code,
  output reg o_conv_start
);

  // control registers
  reg ctrla_en_ff;
  reg [1:0] ctrl2_ff;
  reg [2:0] evt_ctrl_ff;
  reg [1:0] inten_ff;
  reg [1:0] flag_ff;

  // data path state
  reg [15:0] stg_ff;
  reg stg_valid_ff;
  reg [15:0] data_ff;
  reg [3:0] sub_cnt_ff;
  reg was_empty_ff;

  // start-event synchroniser and edge history
  reg evt_meta_ff;
  reg evt_sync_ff;
  reg evt_prev_ff;

  // apb decode
  wire apb_acc;
  wire apb_done;
  wire [3:0] idx;
  wire aligned;
  wire wr_done;
  reg hit;
  reg [31:0] rdata;
  wire nxt_pready;
  wire stall;

  // fifo hookup
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [15:0] fifo_out_data;
  wire fifo_pop;

  // event and conversion terms
  wire dither_on;
  wire left_on;
  wire evt_rise;
  wire evt_fall;
  wire evt_edge;
  wire evt_take;
  wire need_load;
  wire underrun;
  wire load;
  wire conv;
  wire path_empty;
  wire empty_now;
  wire [15:0] use_data;
  reg [9:0] base_code;
  reg [3:0] dither_bits;
  reg [9:0] nxt_code;
  wire [1:0] flag_set;

  assign apb_acc = i_psel & i_penable;
  assign apb_done = apb_acc & o_pready;
  assign idx = i_paddr[5:2];
  assign aligned = (i_paddr[1:0] == 2'b00) && (i_paddr[7:6] == 2'b00);
  assign wr_done = apb_done & i_pwrite & hit;

  always @* begin
    hit = aligned;
    rdata = 32'h0000_0000;
    case (idx)
      `DDE_IDX_CTRLA: begin
        rdata[`DDE_CTRLA_ENABLE] = ctrla_en_ff;
      end
      `DDE_IDX_CTRL2: begin
        rdata[1:0] = ctrl2_ff;
      end
      `DDE_IDX_EVT_CTRL: begin
        rdata[2:0] = evt_ctrl_ff;
      end
      `DDE_IDX_IRQ_CLR, `DDE_IDX_IRQ_SET: begin
        rdata[1:0] = inten_ff;
      end
      `DDE_IDX_INTFLAG: begin
        rdata[1:0] = flag_ff;
      end
      `DDE_IDX_STATUS: begin
        rdata[7:0] = {sub_cnt_ff, 2'b00, fifo_out_valid, stg_valid_ff};
      end
      `DDE_IDX_DATA: begin
        rdata[15:0] = data_ff;
      end
      `DDE_IDX_STAGE: begin
        rdata[15:0] = stg_ff;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // a write into a full queue is held off, so the source really stalls
  assign stall = i_pwrite & hit & (idx == `DDE_IDX_STAGE) & ~fifo_in_ready;
  assign nxt_pready = apb_acc & ~o_pready & ~stall;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= nxt_pready;
      if (nxt_pready) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : (hit ? rdata : 32'h0000_0000);
        o_pslverr <= ~hit;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // control register writes
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrla_en_ff <= `DDE_RST_CTRLA;
      ctrl2_ff <= `DDE_RST_CTRL2;
      evt_ctrl_ff <= `DDE_RST_EVT_CTRL;
    end else if (wr_done) begin
      if (idx == `DDE_IDX_CTRLA) begin
        ctrla_en_ff <= i_pwdata[`DDE_CTRLA_ENABLE];
      end
      if (idx == `DDE_IDX_CTRL2) begin
        ctrl2_ff <= i_pwdata[1:0];
      end
      if (idx == `DDE_IDX_EVT_CTRL) begin
        evt_ctrl_ff <= i_pwdata[2:0];
      end
    end
  end

  // one enable store behind both the set and clear addresses
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      inten_ff <= `DDE_RST_INTEN;
    end else if (wr_done && idx == `DDE_IDX_IRQ_CLR) begin
      inten_ff <= inten_ff & ~i_pwdata[1:0];
    end else if (wr_done && idx == `DDE_IDX_IRQ_SET) begin
      inten_ff <= inten_ff | i_pwdata[1:0];
    end
  end

  // staging queue feeding the staging buffer
  assign fifo_in_valid = wr_done & (idx == `DDE_IDX_STAGE);
  assign fifo_out_ready = ~stg_valid_ff;
  assign fifo_pop = fifo_out_valid & fifo_out_ready;

  dde_fifo #(
    .W(16),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_pwdata[15:0]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // start event: two flip-flops, then edge history
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_meta_ff <= 1'b0;
      evt_sync_ff <= 1'b0;
      evt_prev_ff <= 1'b0;
    end else begin
      evt_meta_ff <= i_start_evt;
      evt_sync_ff <= evt_meta_ff;
      evt_prev_ff <= evt_sync_ff;
    end
  end

  assign evt_rise = evt_sync_ff & ~evt_prev_ff;
  assign evt_fall = ~evt_sync_ff & evt_prev_ff;
  assign evt_edge = evt_ctrl_ff[`DDE_EV_EDGE_INVERT] ? evt_fall : evt_rise;
  assign evt_take = evt_edge & evt_ctrl_ff[`DDE_EV_START_IN_EN] & ctrla_en_ff;

  assign dither_on = ctrl2_ff[`DDE_CTRL2_DITHER];
  assign left_on = ctrl2_ff[`DDE_CTRL2_LEFT_ALIGN];

  // in dither mode only the first of sixteen events pulls new data
  assign need_load = ~dither_on | (sub_cnt_ff == 4'h0);
  assign underrun = evt_take & need_load & ~stg_valid_ff;
  assign load = evt_take & need_load & stg_valid_ff;
  // on underrun no conversion starts; the old code stays on the output
  assign conv = evt_take & ~underrun;
  assign use_data = load ? stg_ff : data_ff;

  always @* begin
    base_code = 10'h000;
    dither_bits = 4'h0;
    if (dither_on) begin
      if (left_on) begin
        base_code = use_data[15:6];
        dither_bits = use_data[5:2];
      end else begin
        base_code = use_data[13:4];
        dither_bits = use_data[3:0];
      end
    end else begin
      base_code = left_on ? use_data[15:6] : use_data[9:0];
    end
    // code plus one, below the maximum code, for the first dither_bits sub-conversions of sixteen
    if (dither_on && (sub_cnt_ff < dither_bits) && (base_code != `DDE_CODE_MAX)) begin
      nxt_code = base_code + 10'h001;
    end else begin
      nxt_code = base_code;
    end
  end

  // staging buffer and conversion register
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stg_ff <= `DDE_RST_DATA;
      stg_valid_ff <= 1'b0;
      data_ff <= `DDE_RST_DATA;
    end else begin
      if (fifo_pop) begin
        stg_ff <= fifo_out_data;
        stg_valid_ff <= 1'b1;
      end else if (load) begin
        stg_valid_ff <= 1'b0;
      end
      if (load) begin
        data_ff <= stg_ff;
      end
    end
  end

  // sub-conversion counter wraps after sixteen conversions
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sub_cnt_ff <= 4'h0;
    end else if (!dither_on) begin
      sub_cnt_ff <= 4'h0;
    end else if (conv) begin
      sub_cnt_ff <= sub_cnt_ff + 4'h1;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dac_code <= 10'h000;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= conv;
      if (conv) begin
        o_dac_code <= nxt_code;
      end
    end
  end

  // empty means nothing left queued or staged for the next load
  assign path_empty = ~stg_valid_ff & ~fifo_out_valid;
  assign empty_now = path_empty & ~was_empty_ff;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      was_empty_ff <= 1'b1;
      o_empty_evt <= 1'b0;
      o_dma_req <= 1'b0;
    end else begin
      was_empty_ff <= path_empty;
      o_empty_evt <= empty_now & evt_ctrl_ff[`DDE_EV_EMPTY_OUT_EN];
      o_dma_req <= path_empty & ctrla_en_ff;
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  assign flag_set = {empty_now, underrun};

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_ff <= `DDE_RST_FLAG;
    end else if (wr_done && idx == `DDE_IDX_INTFLAG) begin
      flag_ff <= (flag_ff & ~i_pwdata[1:0]) | flag_set;
    end else begin
      flag_ff <= flag_ff | flag_set;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flag_ff & inten_ff);
    end
  end

endmodule // dde_ctrl
`default_nettype wire

// ### testbench/dde_ctrl_properties.sv
/* checker: port-level properties of dde_ctrl, bound to its top ports.
   assumes one rising-edge clock and the active-high reset of the top. */
`timescale 1ns/1ps
`default_nettype none
module dde_props (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // events and converter
  input wire o_empty_evt,
  input wire o_dma_req,
  input wire [9:0] o_dac_code,
  input wire o_conv_start
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_conv_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("conv start too wide");
  property p_code_hold; !o_conv_start |-> $stable(o_dac_code); endproperty
  a_code_hold: assert property (p_code_hold) else $error("code moved without start");
  property p_empty_pulse; o_empty_evt |=> !o_empty_evt; endproperty
  a_empty_pulse: assert property (p_empty_pulse) else $error("empty event too wide");
  property p_empty_dma; o_empty_evt |-> o_dma_req; endproperty
  a_empty_dma: assert property (p_empty_dma) else $error("empty event without dma request");
  property p_ready_bound; $rose(i_penable) && i_psel |-> ##[1:40] o_pready; endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("no apb answer");
  property p_ready_access; o_pready |-> i_psel && i_penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_write_zero; o_pready && i_pwrite |-> o_prdata == 32'h0; endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned data");
  property p_err_ready; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // dde_props

bind dde_ctrl dde_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_empty_evt(o_empty_evt), .o_dma_req(o_dma_req), .o_dac_code(o_dac_code), .o_conv_start(o_conv_start));
`default_nettype wire

// ### testbench/dde_evt_src.sv
/* event source partner: drives the start-event line level.
   assumes the caller spaces edges at least two cycles apart. */
`timescale 1ns/1ps
`default_nettype none
module dde_evt_src (
  // clock
  input wire i_clk,
  // start event line
  output var logic o_evt
);
  initial o_evt = 1'b0;
  // at most one edge per call; thirty-two calls per value in dither runs
  task automatic drive(input logic lvl, input int hold);
    @(posedge i_clk);
    o_evt <= lvl;
    repeat (hold) @(posedge i_clk);
  endtask
endmodule // dde_evt_src
`default_nettype wire

// ### testbench/tb_top.sv
/* tb_top: apb-driven bench of dde_ctrl with the event source partner.
   assumes the 50 MHz clock and active-high reset made here. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, evt, empty_evt, dma, irq, conv, err;
  logic [9:0] code, base;
  logic [15:0] vals [3] = '{16'h1210, 16'h12e0, 16'h3ff5};
  logic [1:0] modes [3] = '{2'h3, 2'h3, 2'h1};
  logic [3:0] dith;
  int error_cnt = 0, checks = 0, cyc = 0, n_empty = 0, ne;
  always #10 i_clk = ~i_clk;
  dde_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_start_evt(evt), .o_empty_evt(empty_evt), .o_dma_req(dma), .o_irq(irq),
    .o_dac_code(code), .o_conv_start(conv));
  dde_evt_src u_src (.i_clk(i_clk), .o_evt(evt));
  task end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (empty_evt) n_empty <= n_empty + 1;
    if (cyc > 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
    @(posedge i_clk);
    pen <= 1;
    // the bench timeout cuts a missing answer short
    do @(posedge i_clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 0; pen <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  // one edge on the line, then a bounded wait for the conversion start
  task fire(input logic lvl, input logic exp);
    int n;
    n = 0;
    u_src.drive(lvl, 1);
    while (conv !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      n++;
    end
    chk(n < 8, exp);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 0;
    rd_chk(8'h08, 0);
    rd_chk(8'h10, 0);
    apb(1, 8'h14, 3);
    apb(1, 8'h10, 0);
    rd_chk(8'h10, 3);
    apb(1, 8'h10, 2);
    rd_chk(8'h14, 1);
    apb(0, 8'h0c, 0);
    chk(err, 1);
    apb(1, 8'h00, 1);
    apb(1, 8'h08, 3);
    apb(1, 8'h24, 32'h0123);
    repeat (3) @(posedge i_clk);
    fire(1, 1);
    chk(code, 10'h123);
    rd_chk(8'h20, 32'h0123);
    chk(n_empty, 1);
    chk(dma, 1);
    fire(0, 0);
    fire(1, 0);
    rd_chk(8'h18, 3);
    chk(irq, 1);
    apb(1, 8'h08, 5);
    apb(1, 8'h24, 32'h0200);
    repeat (3) @(posedge i_clk);
    fire(0, 1);
    chk(code, 10'h200);
    chk(n_empty, 1);
    apb(1, 8'h18, 3);
    apb(1, 8'h08, 3);
    for (int v = 0; v < 3; v++) begin
      apb(1, 8'h04, {30'h0, modes[v]});
      base = modes[v][1] ? vals[v][15:6] : vals[v][13:4];
      dith = modes[v][1] ? vals[v][5:2] : vals[v][3:0];
      apb(1, 8'h24, {16'h0, vals[v]});
      repeat (3) @(posedge i_clk);
      ne = n_empty;
      chk(dma, 0);
      for (int i = 0; i < 16; i++) begin
        u_src.drive(0, 1);
        fire(1, 1);
        chk(code, base + ((i < dith && base != 10'h3ff) ? 10'h1 : 10'h0));
      end
      chk(n_empty - ne, 1);
    end
    // left alignment without dither: code from bits 15:6
    apb(1, 8'h04, 32'h2);
    apb(1, 8'h24, 32'h8040);
    repeat (3) @(posedge i_clk);
    u_src.drive(0, 1);
    fire(1, 1);
    chk(code, 10'h201);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
